// >>> hdl/eig_pkg.sv
// eig_pkg: register map, field layout, reset values and mode codes
// for the eight-pin edge-interrupt port.
// assumes a 32-bit apb bus with one word per register.
package eig_pkg;

    // ==========================================================
    // widths
    // ==========================================================
    localparam int NPINS = 8;
    localparam int AW    = 12;

    // ==========================================================
    // register indices (byte address is four times the index)
    // ==========================================================
    localparam logic [7:0] IDX_MODE_UPPER = 8'hec;
    localparam logic [7:0] IDX_MODE_LOWER = 8'hed;
    localparam logic [7:0] IDX_PULLUP     = 8'hee;
    localparam logic [7:0] IDX_PIN_DATA   = 8'hf2;
    localparam logic [7:0] IDX_OUT_TYPE   = 8'hf3;
    localparam logic [7:0] IDX_IRQ_EN     = 8'he5;
    localparam logic [7:0] IDX_IRQ_PEND   = 8'he6;

    localparam logic [AW-1:0] ADDR_MODE_UPPER = {2'b00, IDX_MODE_UPPER, 2'b00};
    localparam logic [AW-1:0] ADDR_MODE_LOWER = {2'b00, IDX_MODE_LOWER, 2'b00};
    localparam logic [AW-1:0] ADDR_PULLUP     = {2'b00, IDX_PULLUP, 2'b00};
    localparam logic [AW-1:0] ADDR_PIN_DATA   = {2'b00, IDX_PIN_DATA, 2'b00};
    localparam logic [AW-1:0] ADDR_OUT_TYPE   = {2'b00, IDX_OUT_TYPE, 2'b00};
    localparam logic [AW-1:0] ADDR_IRQ_EN     = {2'b00, IDX_IRQ_EN, 2'b00};
    localparam logic [AW-1:0] ADDR_IRQ_PEND   = {2'b00, IDX_IRQ_PEND, 2'b00};

    // ==========================================================
    // reset values
    // ==========================================================
    localparam logic [7:0] RST_MODE     = 8'h00;
    localparam logic [7:0] RST_PULLUP   = 8'h00;
    localparam logic [7:0] RST_PIN_DATA = 8'h00;
    localparam logic [7:0] RST_OUT_TYPE = 8'h00;
    localparam logic [7:0] RST_IRQ_EN   = 8'h00;
    localparam logic [7:0] RST_IRQ_PEND = 8'h00;

    // ==========================================================
    // two-bit pin mode codes
    // ==========================================================
    localparam logic [1:0] MODE_IN_FALL = 2'h0;
    localparam logic [1:0] MODE_IN_BOTH = 2'h1;
    localparam logic [1:0] MODE_OUTPUT  = 2'h2;
    localparam logic [1:0] MODE_IN_RISE = 2'h3;

    // output-type bit values
    localparam logic OTYPE_PUSH_PULL  = 1'b0;
    localparam logic OTYPE_OPEN_DRAIN = 1'b1;

endpackage : eig_pkg

// >>> hdl/eig_pin_edge.sv
// eig_pin_edge: one pin's two-stage synchroniser and edge detector.
// assumes pin_in is asynchronous to pclk.
`timescale 1ns/1ns
module eig_pin_edge (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // pin and mode
    input  wire logic       pin_in,
    input  wire logic [1:0] mode,
    // results
    output logic            level,
    output logic            edge_hit
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } eig_pin_state_t;

    eig_pin_state_t s_r;
    eig_pin_state_t s_nxt;
    logic           rise;
    logic           fall;

    // ==========================================================
    // sampling
    // ==========================================================
    always_comb begin
        s_nxt      = s_r;
        s_nxt.meta = pin_in;
        s_nxt.sync = s_r.meta;
        s_nxt.prev = s_r.sync;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // edge select by mode
    // ==========================================================
    assign rise  = s_r.sync & ~s_r.prev;
    assign fall  = ~s_r.sync & s_r.prev;
    assign level = s_r.sync;

    always_comb begin
        unique case (mode)
            eig_pkg::MODE_IN_FALL: edge_hit = fall;
            eig_pkg::MODE_IN_BOTH: edge_hit = rise | fall;
            eig_pkg::MODE_IN_RISE: edge_hit = rise;
            eig_pkg::MODE_OUTPUT:  edge_hit = 1'b0;
        endcase
    end

endmodule : eig_pin_edge

// >>> hdl/eig_gpio_port.sv
// eig_gpio_port: eight-pin general-purpose port with per-pin modes,
// edge interrupts, pull-up and output-type control, apb slave.
// assumes pins are asynchronous and apb runs on pclk.
//
// Behaviour
// - data register reads pins, writes outputs
// - two mode registers, two bits per pin
// - reset clears mode registers: all inputs
// - mode 00: input, falling-edge interrupt
// - mode 01: input, both-edge interrupt
// - mode 10: output, push-pull or open-drain
// - mode 11: input, rising-edge interrupt
// - lower register: pins 0-3, sources five-eight
// - upper register: pins 4-7 (pin 4 at bits 1:0), shared source nine
// - per-pin pull-up enable register
// - output type: 0 push-pull, 1 open-drain
// - per-pin interrupt enable gates the request
// - pending flag set on selected edge
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ns
module eig_gpio_port (
    // clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // apb slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [eig_pkg::AW-1:0]  paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // port pins
    input  wire logic [7:0]              pin_in,
    output logic      [7:0]              pin_out,
    output logic      [7:0]              pin_oe,
    output logic      [7:0]              pullup_on,
    // interrupt requests
    output logic                         irq_source_five,
    output logic                         irq_source_six,
    output logic                         irq_source_seven,
    output logic                         irq_source_eight,
    output logic                         irq_source_nine_shared
);

    // ==========================================================
    // state
    // ==========================================================
    typedef struct packed {
        logic [7:0]  pin_mode_upper;
        logic [7:0]  pin_mode_lower;
        logic [7:0]  pullup_enable;
        logic [7:0]  port_pin_data;
        logic [7:0]  output_type_select;
        logic [7:0]  edge_irq_enable;
        logic [7:0]  edge_irq_pending;
        logic [31:0] rdata;
    } eig_port_state_t;

    eig_port_state_t s_r;
    eig_port_state_t s_nxt;

    logic [15:0] modes;
    logic [7:0]  level;
    logic [7:0]  hit;
    logic [7:0]  req;
    logic [7:0]  is_out;
    logic        setup_rd;
    logic        acc_wr;
    logic        acc;
    logic        mapped;
    logic [7:0]  wbyte;
    logic        wlane;
    logic        wr_en;
    // register decode
    logic        sel_mode_upper;
    logic        sel_mode_lower;
    logic        sel_pullup;
    logic        sel_pin_data;
    logic        sel_out_type;
    logic        sel_irq_en;
    logic        sel_irq_pend;
    logic        wr_mode_upper;
    logic        wr_mode_lower;
    logic        wr_pullup;
    logic        wr_pin_data;
    logic        wr_out_type;
    logic        wr_irq_en;
    logic        wr_irq_pend;
    logic [7:0]  rd_byte;
    // pending and requests
    logic [7:0]  pend_clr;
    logic [7:0]  pend_set;
    logic [3:0]  req_single;
    logic        req_shared;

    // ==========================================================
    // pin mode fields
    // ==========================================================
    // pin i sits at bits 2i+1:2i of {upper, lower}
    assign modes = {s_r.pin_mode_upper, s_r.pin_mode_lower};

    // ==========================================================
    // per-pin edge detection
    // ==========================================================
    genvar gi;
    generate
        for (gi = 0; gi < eig_pkg::NPINS; gi++) begin : g_pin
            eig_pin_edge u_edge (
                .pclk     (pclk),
                .presetn  (presetn),
                .pin_in   (pin_in[gi]),
                .mode     (modes[2*gi+1:2*gi]),
                .level    (level[gi]),
                .edge_hit (hit[gi])
            );
            assign is_out[gi] = (modes[2*gi+1:2*gi] == eig_pkg::MODE_OUTPUT);
        end
    endgenerate

    // ==========================================================
    // apb decode
    // ==========================================================
    assign acc      = psel & penable;
    assign acc_wr   = acc & pwrite;
    assign setup_rd = psel & ~penable & ~pwrite;
    assign wlane    = pstrb[0];
    assign wbyte    = pwdata[7:0];
    assign wr_en    = acc_wr & wlane;

    // ==========================================================
    // register selects
    // ==========================================================
    // one-hot: each aligned word maps one register
    assign sel_mode_upper = (paddr == eig_pkg::ADDR_MODE_UPPER);
    assign sel_mode_lower = (paddr == eig_pkg::ADDR_MODE_LOWER);
    assign sel_pullup     = (paddr == eig_pkg::ADDR_PULLUP);
    assign sel_pin_data   = (paddr == eig_pkg::ADDR_PIN_DATA);
    assign sel_out_type   = (paddr == eig_pkg::ADDR_OUT_TYPE);
    assign sel_irq_en     = (paddr == eig_pkg::ADDR_IRQ_EN);
    assign sel_irq_pend   = (paddr == eig_pkg::ADDR_IRQ_PEND);

    // ==========================================================
    // write strobes
    // ==========================================================
    // only byte lane 0 carries register data
    assign wr_mode_upper  = wr_en & sel_mode_upper;
    assign wr_mode_lower  = wr_en & sel_mode_lower;
    assign wr_pullup      = wr_en & sel_pullup;
    assign wr_pin_data    = wr_en & sel_pin_data;
    assign wr_out_type    = wr_en & sel_out_type;
    assign wr_irq_en      = wr_en & sel_irq_en;
    assign wr_irq_pend    = wr_en & sel_irq_pend;

    // ==========================================================
    // read mux
    // ==========================================================
    // output pins read back their pad level
    always_comb begin
        rd_byte = 8'h00;
        if (sel_mode_upper) begin
            rd_byte = s_r.pin_mode_upper;
        end
        if (sel_mode_lower) begin
            rd_byte = s_r.pin_mode_lower;
        end
        if (sel_pullup) begin
            rd_byte = s_r.pullup_enable;
        end
        if (sel_pin_data) begin
            rd_byte = level;
        end
        if (sel_out_type) begin
            rd_byte = s_r.output_type_select;
        end
        if (sel_irq_en) begin
            rd_byte = s_r.edge_irq_enable;
        end
        if (sel_irq_pend) begin
            rd_byte = s_r.edge_irq_pending;
        end
    end

    // ==========================================================
    // pending flag set and clear
    // ==========================================================
    // set beats clear, so no edge is ever lost
    assign pend_set = hit;
    assign pend_clr = wr_irq_pend ? ~wbyte : 8'h00;

    always_comb begin
        unique case (paddr)
            eig_pkg::ADDR_MODE_UPPER,
            eig_pkg::ADDR_MODE_LOWER,
            eig_pkg::ADDR_PULLUP,
            eig_pkg::ADDR_PIN_DATA,
            eig_pkg::ADDR_OUT_TYPE,
            eig_pkg::ADDR_IRQ_EN,
            eig_pkg::ADDR_IRQ_PEND: mapped = 1'b1;
            default:                mapped = 1'b0;
        endcase
    end

    // zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata  = s_r.rdata;

    // ==========================================================
    // next state
    // ==========================================================
    always_comb begin
        s_nxt = s_r;

        // read data captured in the setup cycle, shown in access
        if (setup_rd) begin
            s_nxt.rdata = {24'h00_0000, rd_byte};
        end

        // register writes take effect at the access edge
        if (wr_mode_upper) begin
            s_nxt.pin_mode_upper = wbyte;
        end
        if (wr_mode_lower) begin
            s_nxt.pin_mode_lower = wbyte;
        end
        if (wr_pullup) begin
            s_nxt.pullup_enable = wbyte;
        end
        if (wr_pin_data) begin
            s_nxt.port_pin_data = wbyte;
        end
        if (wr_out_type) begin
            s_nxt.output_type_select = wbyte;
        end
        if (wr_irq_en) begin
            s_nxt.edge_irq_enable = wbyte;
        end

        // pending: write 0 clears a bit, write 1 keeps it;
        // a fresh edge in the same cycle wins over the clear
        s_nxt.edge_irq_pending = (s_r.edge_irq_pending & ~pend_clr) | pend_set;
    end

    // ==========================================================
    // registers
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r.pin_mode_upper     <= eig_pkg::RST_MODE;
            s_r.pin_mode_lower     <= eig_pkg::RST_MODE;
            s_r.pullup_enable      <= eig_pkg::RST_PULLUP;
            s_r.port_pin_data      <= eig_pkg::RST_PIN_DATA;
            s_r.output_type_select <= eig_pkg::RST_OUT_TYPE;
            s_r.edge_irq_enable    <= eig_pkg::RST_IRQ_EN;
            s_r.edge_irq_pending   <= eig_pkg::RST_IRQ_PEND;
            s_r.rdata              <= 32'h0000_0000;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // pin drivers
    // ==========================================================
    // open-drain drives only low; push-pull drives both levels
    always_comb begin
        for (int i = 0; i < eig_pkg::NPINS; i++) begin
            if (!is_out[i]) begin
                pin_out[i] = 1'b0;
                pin_oe[i]  = 1'b0;
            end else if (s_r.output_type_select[i] == eig_pkg::OTYPE_OPEN_DRAIN) begin
                pin_out[i] = 1'b0;
                pin_oe[i]  = ~s_r.port_pin_data[i];
            end else begin
                pin_out[i] = s_r.port_pin_data[i];
                pin_oe[i]  = 1'b1;
            end
        end
    end

    // pull-ups act on inputs only
    assign pullup_on = s_r.pullup_enable & ~is_out;

    // ==========================================================
    // interrupt requests
    // ==========================================================
    assign req = s_r.edge_irq_pending & s_r.edge_irq_enable;

    // pins 4-7 share one request line
    assign req_single = req[3:0];
    assign req_shared = |req[7:4];

    assign irq_source_five        = req_single[0];
    assign irq_source_six         = req_single[1];
    assign irq_source_seven       = req_single[2];
    assign irq_source_eight       = req_single[3];
    assign irq_source_nine_shared = req_shared;

endmodule : eig_gpio_port

// >>> verification/eig_chk.sv
// eig_chk: port-level assertions for eig_gpio_port.
// assumes it is bound onto the port; one pclk domain.
`timescale 1ns/1ns
module eig_chk (
    // clock and reset
    input logic                   pclk,
    input logic                   presetn,
    // apb
    input logic                   psel,
    input logic                   penable,
    input logic                   pwrite,
    input logic [eig_pkg::AW-1:0] paddr,
    input logic [31:0]            prdata,
    input logic                   pready,
    input logic                   pslverr,
    // pins and requests
    input logic [7:0]             pin_in,
    input logic [7:0]             pin_out,
    input logic [7:0]             pin_oe,
    input logic [7:0]             pullup_on,
    input logic                   irq_source_five,
    input logic                   irq_source_nine_shared
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence acc_s; psel && penable; endsequence
    sequence bad_rd_s; acc_s ##0 (!pwrite && pslverr); endsequence
    ready_high_a: assert property (pready) else $error("pready low");
    err_phase_a: assert property (!(psel && penable) |-> !pslverr)
        else $error("pslverr outside access");
    err_hole_a: assert property (acc_s ##0 (paddr == 12'h000) |-> pslverr)
        else $error("unmapped access not refused");
    bad_read_a: assert property (bad_rd_s |-> prdata == 32'h0) else $error("refused read not zero");
    oe_cause_a: assert property (!$stable(pin_oe) |-> $past(psel && penable && pwrite))
        else $error("pin_oe moved without write");
    out_cause_a: assert property (!$stable(pin_out) |-> $past(psel && penable && pwrite))
        else $error("pin_out moved without write");
    pull_cause_a: assert property (!$stable(pullup_on) |-> $past(psel && penable && pwrite))
        else $error("pullup moved without write");
    pull_out_a: assert property ((pullup_on & pin_oe) == 8'h00) else $error("pullup on driven pin");
    irq_sticky_a: assert property ($fell(irq_source_nine_shared) |-> $past(psel && penable && pwrite))
        else $error("request dropped without write");
    irq_cause_a: assert property ($rose(irq_source_five) |->
        $past(psel && penable && pwrite) || $past(pin_in[0], 2) != $past(pin_in[0], 5))
        else $error("request without edge or write");
    reset_in_a: assert property ($rose(presetn) |-> pin_oe == 8'h00) else $error("pin driven after reset");
endmodule : eig_chk

bind eig_gpio_port eig_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
    .irq_source_five(irq_source_five), .irq_source_nine_shared(irq_source_nine_shared));

// >>> verification/eig_pins_model.sv
// eig_pins_model: outside circuitry on the eight port pins.
// assumes the bench sets ext_val and ext_en; the port's drive wins.
`timescale 1ns/1ns
module eig_pins_model (
    // port side
    input  logic [7:0] pin_out,
    input  logic [7:0] pin_oe,
    input  logic [7:0] pullup_on,
    // bench side
    input  logic [7:0] ext_val,
    input  logic [7:0] ext_en,
    // resolved levels
    output logic [7:0] pin_in
);
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else if (pullup_on[i])
                pin_in[i] = 1'b1;
            else
                pin_in[i] = ~ext_val[i];
        end
    end
endmodule : eig_pins_model

// >>> verification/tb.sv
// tb: self-checking bench for eig_gpio_port over apb.
// assumes eig_pins_model and the bound checker are compiled.
`timescale 1ns/1ns
module tb;
    logic                   pclk = 1'b0;
    logic                   presetn = 1'b0;
    logic                   psel = 1'b0;
    logic                   penable = 1'b0;
    logic                   pwrite = 1'b0;
    logic [eig_pkg::AW-1:0] paddr = 12'h000;
    logic [31:0]            pwdata = 32'h0;
    logic [3:0]             pstrb = 4'hf;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic [7:0]             pin_in, pin_out, pin_oe, pullup_on;
    logic [7:0]             ext_val = 8'h00;
    logic [7:0]             ext_en = 8'hff;
    logic [4:0]             irq;
    int                     fail_count = 0;
    int                     check_count = 0;

    always #4 pclk = ~pclk;

    eig_gpio_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
        .irq_source_five(irq[0]), .irq_source_six(irq[1]), .irq_source_seven(irq[2]),
        .irq_source_eight(irq[3]), .irq_source_nine_shared(irq[4]));
    eig_pins_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
        .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        apb(a, 1'b1, d, q);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        logic [31:0] q;
        apb(a, 1'b0, 8'h00, q);
        chk(q, {24'h0, e});
    endtask : rd

    task automatic pins(input logic [7:0] oe, input logic [7:0] pu);
        repeat (4) @(posedge pclk);
        chk({16'h0, pin_oe, pullup_on}, {16'h0, oe, pu});
    endtask : pins

    task automatic irqs(input logic [4:0] e);
        @(posedge pclk);
        chk({27'h0, irq}, {27'h0, e});
    endtask : irqs

    task automatic t_reset;
        logic [11:0] a [7] = '{eig_pkg::ADDR_MODE_UPPER, eig_pkg::ADDR_MODE_LOWER, eig_pkg::ADDR_PULLUP,
            eig_pkg::ADDR_OUT_TYPE, eig_pkg::ADDR_IRQ_EN, eig_pkg::ADDR_IRQ_PEND, eig_pkg::ADDR_PIN_DATA};
        foreach (a[i]) rd(a[i], 8'h00);
        rd(12'h000, 8'h00);
        pins(8'h00, 8'h00);
        foreach (a[i]) if (i < 5) begin
            wr(a[i], 8'h5a ^ 8'(i));
            rd(a[i], 8'h5a ^ 8'(i));
        end
        pstrb <= 4'h0;
        wr(eig_pkg::ADDR_IRQ_EN, 8'hff);
        pstrb <= 4'hf;
        rd(eig_pkg::ADDR_IRQ_EN, 8'h5e);
        foreach (a[i]) if (i < 5) wr(a[i], 8'h00);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_out;
        ext_en <= 8'he0;
        wr(eig_pkg::ADDR_MODE_LOWER, 8'haa);
        wr(eig_pkg::ADDR_MODE_UPPER, 8'h02);
        wr(eig_pkg::ADDR_PULLUP, 8'hff);
        wr(eig_pkg::ADDR_PIN_DATA, 8'h1b);
        pins(8'h1f, 8'he0);
        chk({24'h0, pin_out & 8'h1f}, 32'h1b);
        rd(eig_pkg::ADDR_PIN_DATA, 8'h1b);
        wr(eig_pkg::ADDR_PIN_DATA, 8'h00);
        wr(eig_pkg::ADDR_OUT_TYPE, 8'h1b);
        pins(8'h1f, 8'he0);
        wr(eig_pkg::ADDR_PIN_DATA, 8'h1b);
        pins(8'h04, 8'he0);
        chk({24'h0, pin_out & 8'h1f}, 32'h0);
        rd(eig_pkg::ADDR_IRQ_PEND, 8'h00);
        wr(eig_pkg::ADDR_PIN_DATA, 8'h00);
        ext_en <= 8'hff;
        wr(eig_pkg::ADDR_OUT_TYPE, 8'h00);
        wr(eig_pkg::ADDR_MODE_LOWER, 8'h00);
        wr(eig_pkg::ADDR_MODE_UPPER, 8'h00);
        wr(eig_pkg::ADDR_PULLUP, 8'h00);
        $display("t_out done");
    endtask : t_out

    task automatic t_edges;
        wr(eig_pkg::ADDR_MODE_LOWER, 8'he4);
        wr(eig_pkg::ADDR_MODE_UPPER, 8'he4);
        ext_val <= 8'hff;
        repeat (6) @(posedge pclk);
        rd(eig_pkg::ADDR_IRQ_PEND, 8'haa);
        rd(eig_pkg::ADDR_PIN_DATA, 8'hbb);
        irqs(5'b00000);
        wr(eig_pkg::ADDR_IRQ_EN, 8'h03);
        irqs(5'b00010);
        wr(eig_pkg::ADDR_IRQ_EN, 8'h88);
        irqs(5'b11000);
        wr(eig_pkg::ADDR_IRQ_PEND, 8'h7f);
        irqs(5'b01000);
        rd(eig_pkg::ADDR_IRQ_PEND, 8'h2a);
        wr(eig_pkg::ADDR_IRQ_PEND, 8'h00);
        wr(eig_pkg::ADDR_IRQ_EN, 8'h11);
        ext_val <= 8'h00;
        repeat (6) @(posedge pclk);
        irqs(5'b10001);
        rd(eig_pkg::ADDR_IRQ_PEND, 8'h33);
        wr(eig_pkg::ADDR_MODE_LOWER, 8'h30);
        wr(eig_pkg::ADDR_IRQ_PEND, 8'h00);
        wr(eig_pkg::ADDR_IRQ_EN, 8'h04);
        ext_val <= 8'h04;
        repeat (6) @(posedge pclk);
        irqs(5'b00100);
        rd(eig_pkg::ADDR_IRQ_PEND, 8'h04);
        $display("t_edges done");
    endtask : t_edges

    task automatic give_verdict;
        $display("checks=%0d fails=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    initial begin
        #200000;
        fail_count++;
        give_verdict();
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_out();
        t_edges();
        give_verdict();
    end
endmodule : tb
